/* File: analog_block_interface_defs.svh */
/*
 * Offsets, field positions, reset values and timing counts for the
 * analog block interface.
 * Assumes a 20 MHz system clock and an 8-bit APB byte address.
 */
// Notes on behaviour
// [RQ1] APB slave is the main control path.
// [RQ2] config mux clock divided down, at most 10 MHz.
// [RQ3] drive every config mux control, clock included.
// [RQ4] conversions start only from APB writes.
// [RQ5] leave reset, calibrate, then accept conversions.
// [RQ6] master configures channels before any conversion.
// [RQ7] registers only for what the macro lacks.
// [RQ8] optional result FIFO, up to 256 entries.
// [RQ9] sampling never stalls until FIFO full.
// [RQ10] almost empty and almost full thresholds reported.
// [RQ11] one interrupt line from fourteen events; only eleven are sourced, bits 13:11 stay zero.
// [RQ12] master reads interrupt status to find cause.
// [RQ13] sticky status, build-time interrupt polarity.
`ifndef ANALOG_BLOCK_INTERFACE_DEFS_SVH
`define ANALOG_BLOCK_INTERFACE_DEFS_SVH

// ==========================================================
// register offsets (byte addresses)
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_RESULT 8'h08
`define OFS_CFG 8'h0c
`define OFS_IRQ_STATUS 8'h10
`define OFS_IRQ_ENABLE 8'h14

// ==========================================================
// field positions
`define CTRL_START_BIT 0
`define CTRL_CHAN_LSB 8
`define CTRL_MODE_LSB 13
`define CFG_WRITE_BIT 16
`define RESULT_VALID_BIT 15

// ==========================================================
// interrupt events
`define IRQ_WIDTH 14
`define EV_CONV_DONE 0
`define EV_CAL_DONE 1
`define EV_FULL 2
`define EV_AFULL 3
`define EV_AEMPTY 4
`define EV_EMPTY 5
`define EV_OVERFLOW 6
`define EV_UNDERFLOW 7
`define EV_CFG_DONE 8
`define EV_START_REFUSED 9
`define EV_CFG_REFUSED 10

// ==========================================================
// build-time options and reset values
`define RESULT_FIFO_ON 1'b1
`define FIFO_DEPTH 256
`define FIFO_AW 8
`define FIFO_AEMPTY_LEVEL 9'h004
`define FIFO_AFULL_LEVEL 9'h0fc
`define IRQ_ACTIVE_HIGH 1'b1
`define ADC_MODE_RESET 2'h0
`define IRQ_ENABLE_RESET 14'h0000

// ==========================================================
// timing
`define SYS_CLK_MHZ 20
`define CFGMUX_MAX_MHZ 10
`define CFGMUX_DIV ((`SYS_CLK_MHZ + `CFGMUX_MAX_MHZ - 1) / `CFGMUX_MAX_MHZ)
`define CFGMUX_HALF ((`CFGMUX_DIV / 2) < 1 ? 1 : (`CFGMUX_DIV / 2))
`define ADC_RST_NS 1000
`define ADC_RST_CYCLES ((`ADC_RST_NS * `SYS_CLK_MHZ + 999) / 1000)

`endif

/* File: analog_block_interface_pkg.sv */
/*
 * Types shared by the analog block interface.
 * Assumes nothing of its surroundings.
 */
package analog_block_interface_pkg;

	// ==========================================================
	// power-up sequence, gray codes along the path
	typedef enum logic [1:0] {
		INIT_RESET = 2'h0,
		INIT_CAL_START = 2'h1,
		INIT_CAL_WAIT = 2'h3,
		INIT_READY = 2'h2
	} init_state_type;

	// ==========================================================
	// config mux transfer
	typedef enum logic [1:0] {
		CFG_IDLE = 2'h0,
		CFG_SETUP = 2'h1,
		CFG_HOLD = 2'h3
	} cfg_state_type;

endpackage

/* File: analog_block_model.sv */
/*
 * behavioural analog block: adc with calibration, config mux memory.
 * assumes sys_clk and the divided config mux clock from the design.
 */
`timescale 1ns/100ps
`default_nettype none

module analog_block_model (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// speed choice from the bench
	input wire logic slow,
	// adc
	input wire logic adc_rst_n,
	input wire logic adc_calibrate,
	input wire logic adc_start,
	input wire logic [4:0] adc_chnum,
	output logic adc_calibrating,
	output logic adc_busy,
	output logic adc_datavalid,
	output logic [11:0] adc_result,
	// config mux port
	input wire logic cfgmux_clk,
	input wire logic cfgmux_wen,
	input wire logic [7:0] cfgmux_addr,
	input wire logic [7:0] cfgmux_wdata,
	output logic [7:0] cfgmux_rdata
);
	logic [7:0] mem [256]; // channel setup store
	logic [4:0] left; // cycles still to wait
	logic [6:0] n_conv; // tags each result word

	// ==========================================================
	// config mux: written on the rising clock
	assign cfgmux_rdata = mem[cfgmux_addr];
	always_ff @(posedge cfgmux_clk) begin
		if (cfgmux_wen) begin
			mem[cfgmux_addr] <= cfgmux_wdata;
		end
	end

	// ==========================================================
	// adc: result line toggles when not valid and out of adc reset, holds while adc_rst_n is low
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			adc_calibrating <= 1'b0;
			adc_busy <= 1'b0;
			adc_datavalid <= 1'b0;
			adc_result <= 12'hfff;
			left <= 5'h00;
			n_conv <= 7'h00;
		end else if (!adc_rst_n) begin
			adc_calibrating <= 1'b0;
			adc_busy <= 1'b0;
		end else begin
			adc_datavalid <= 1'b0;
			adc_result <= ~adc_result;
			if (adc_calibrate) begin
				adc_calibrating <= 1'b1;
				left <= slow ? 5'h14 : 5'h03;
			end else if (adc_start && !adc_busy) begin
				adc_busy <= 1'b1;
				left <= slow ? 5'h0c : 5'h01;
			end else if (left != 5'h00) begin
				left <= left - 5'h01;
			end else if (adc_calibrating) begin
				adc_calibrating <= 1'b0;
			end else if (adc_busy) begin
				adc_busy <= 1'b0;
				adc_datavalid <= 1'b1;
				adc_result <= {adc_chnum, n_conv};
				n_conv <= n_conv + 7'h01;
			end
		end
	end
endmodule
`default_nettype wire

/* File: apb_analog_block_interface.sv */
/*
 * APB slave that controls the analog block: config mux port with
 * its divided clock, ADC start and result collection, power-up
 * calibration, optional result FIFO and one interrupt line.
 * Assumes the analog block macro sits on the other side, clocked
 * from the same 20 MHz system clock; APB inputs are synchronous.
 */
`timescale 1ns/100ps
`default_nettype none
`include "analog_block_interface_defs.svh"

module apb_analog_block_interface (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// analog config mux port
	output logic cfgmux_clk,
	output logic cfgmux_wen,
	output logic [7:0] cfgmux_addr,
	output logic [7:0] cfgmux_wdata,
	input wire logic [7:0] cfgmux_rdata,
	// adc of the analog block
	output logic adc_rst_n,
	output logic adc_calibrate,
	output logic adc_start,
	output logic [4:0] adc_chnum,
	output logic [1:0] adc_mode,
	input wire logic adc_calibrating,
	input wire logic adc_busy,
	input wire logic adc_datavalid,
	input wire logic [11:0] adc_result,
	// interrupt
	output logic irq
);
	import analog_block_interface_pkg::*;

	// ==========================================================
	// apb decode
	wire access = psel & penable & ~pready; // one action per transfer
	wire wr = access & pwrite;
	wire rd = access & ~pwrite;
	wire sel_ctrl = (paddr == `OFS_CTRL);
	wire sel_status = (paddr == `OFS_STATUS);
	wire sel_result = (paddr == `OFS_RESULT);
	wire sel_cfg = (paddr == `OFS_CFG);
	wire sel_irq_status = (paddr == `OFS_IRQ_STATUS);
	wire sel_irq_enable = (paddr == `OFS_IRQ_ENABLE);
	wire mapped = sel_ctrl | sel_status | sel_result | sel_cfg |
		sel_irq_status | sel_irq_enable;

	// ==========================================================
	// state
	init_state_type init_state; // power-up sequence
	cfg_state_type cfg_state; // config mux transfer
	logic [4:0] rst_count; // adc reset hold counter
	logic cal_seen; // calibration busy observed
	logic conv_pending; // start issued, result not yet back
	logic [7:0] div_count; // config mux divider
	logic cfg_pending; // transfer queued by software
	logic cfg_write; // queued transfer is a write
	logic [7:0] cfg_addr_q; // queued address
	logic [7:0] cfg_data_q; // queued write data
	logic [7:0] cfg_read_data; // last data read back
	logic [11:0] last_result; // newest conversion
	logic [`IRQ_WIDTH-1:0] irq_status; // sticky events
	logic [`IRQ_WIDTH-1:0] irq_enable; // event mask
	logic [3:0] level_prev; // flag levels one cycle ago

	// ==========================================================
	// fifo wires
	wire [11:0] fifo_rd_data;
	wire [8:0] fifo_count;
	wire fifo_empty;
	wire fifo_full;
	wire fifo_aempty = (fifo_count <= `FIFO_AEMPTY_LEVEL); // RQ10
	wire fifo_afull = (fifo_count >= `FIFO_AFULL_LEVEL); // RQ10
	wire result_rd = rd & sel_result;
	wire fifo_pop = result_rd & ~fifo_empty;

	// ==========================================================
	// control decode
	wire adc_ready = (init_state == INIT_READY);
	wire start_req = wr & sel_ctrl & pwdata[`CTRL_START_BIT];
	// a start while the adc is not free is refused, not queued
	wire start_ok = start_req & adc_ready & ~adc_busy & ~conv_pending;
	wire cfg_busy = cfg_pending | (cfg_state != CFG_IDLE);
	wire cfg_req = wr & sel_cfg;
	wire cfg_ok = cfg_req & ~cfg_busy;
	wire div_tick = (div_count == 8'(`CFGMUX_HALF - 1));
	wire fall_tick = div_tick & cfgmux_clk; // clock about to fall
	wire rise_tick = div_tick & ~cfgmux_clk; // clock about to rise
	wire cfg_done = fall_tick & (cfg_state == CFG_HOLD);
	wire cal_done = (init_state == INIT_CAL_WAIT) & cal_seen &
		~adc_calibrating;
	wire irq_any = |(irq_status & irq_enable);

	// ==========================================================
	// event vector
	wire [3:0] levels = {fifo_full, fifo_afull, fifo_aempty, fifo_empty};
	wire [3:0] level_rise = levels & ~level_prev;
	wire [`IRQ_WIDTH-1:0] events;
	assign events[`EV_CONV_DONE] = adc_datavalid;
	assign events[`EV_CAL_DONE] = cal_done;
	assign events[`EV_FULL] = level_rise[3];
	assign events[`EV_AFULL] = level_rise[2];
	assign events[`EV_AEMPTY] = level_rise[1];
	assign events[`EV_EMPTY] = level_rise[0];
	assign events[`EV_OVERFLOW] = adc_datavalid & fifo_full;
	assign events[`EV_UNDERFLOW] = result_rd & fifo_empty;
	assign events[`EV_CFG_DONE] = cfg_done;
	assign events[`EV_START_REFUSED] = start_req & ~start_ok;
	assign events[`EV_CFG_REFUSED] = cfg_req & cfg_busy;
	assign events[`IRQ_WIDTH-1:`EV_CFG_REFUSED+1] = '0; // spare events
	wire [`IRQ_WIDTH-1:0] irq_clear = (wr & sel_irq_status) ?
		pwdata[`IRQ_WIDTH-1:0] : '0;

	// ==========================================================
	// read mux
	wire [31:0] status_word = {15'h0000, fifo_count, 1'b0, fifo_full,
		fifo_afull, fifo_aempty, fifo_empty, cfg_busy, adc_busy, adc_ready};
	wire [31:0] result_word = {16'h0000, ~fifo_empty, 3'h0, fifo_rd_data};
	wire [31:0] ctrl_word = {17'h00000, adc_mode, adc_chnum, 8'h00};
	wire [31:0] cfg_word = {15'h0000, cfg_write, cfg_addr_q, cfg_read_data};
	wire [31:0] read_word =
		sel_ctrl ? ctrl_word :
		sel_status ? status_word :
		sel_result ? result_word :
		sel_cfg ? cfg_word :
		sel_irq_status ? {18'h00000, irq_status} :
		sel_irq_enable ? {18'h00000, irq_enable} : 32'h00000000;

	// ==========================================================
	// result storage, fifo when built in, else one holding word
	generate
		if (`RESULT_FIFO_ON) begin : g_fifo
			// sampling keeps going, words only drop once full
			result_fifo u_result_fifo ( // RQ8 RQ9
				.sys_clk(sys_clk),
				.rst(rst),
				.push(adc_datavalid),
				.wr_data(adc_result),
				.pop(fifo_pop),
				.rd_data(fifo_rd_data),
				.count(fifo_count),
				.empty(fifo_empty),
				.full(fifo_full)
			);
		end else begin : g_single
			logic held; // holding word valid
			assign fifo_rd_data = last_result;
			assign fifo_count = {8'h00, held};
			assign fifo_empty = ~held;
			assign fifo_full = held;
			always_ff @(posedge sys_clk or posedge rst) begin
				if (rst) begin
					held <= 1'b0;
				end else begin
					held <= adc_datavalid | (held & ~fifo_pop);
				end
			end
		end
	endgenerate

	// ==========================================================
	// apb answer: access cycle, then registered data with pready
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= access; // RQ1
			pslverr <= access & ~mapped;
			if (rd) begin
				prdata <= read_word;
			end
		end
	end

	// ==========================================================
	// power-up: hold adc in reset, calibrate, then ready
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			init_state <= INIT_RESET;
			rst_count <= 5'h00;
			cal_seen <= 1'b0;
			adc_rst_n <= 1'b0;
			adc_calibrate <= 1'b0;
		end else begin
			adc_calibrate <= 1'b0;
			unique case (init_state)
				INIT_RESET: begin
					if (rst_count == 5'(`ADC_RST_CYCLES - 1)) begin
						adc_rst_n <= 1'b1; // RQ5
						init_state <= INIT_CAL_START;
					end else begin
						rst_count <= rst_count + 5'h01;
					end
				end
				INIT_CAL_START: begin
					adc_calibrate <= 1'b1; // RQ5
					init_state <= INIT_CAL_WAIT;
				end
				INIT_CAL_WAIT: begin
					// the macro must first show busy, then drop it
					cal_seen <= cal_seen | adc_calibrating;
					if (cal_done) begin
						init_state <= INIT_READY; // RQ5
					end
				end
				INIT_READY: begin
					init_state <= INIT_READY;
				end
			endcase
		end
	end

	// ==========================================================
	// conversion control, driven only by apb writes
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			adc_start <= 1'b0;
			adc_chnum <= 5'h00;
			adc_mode <= `ADC_MODE_RESET;
			conv_pending <= 1'b0;
			last_result <= 12'h000;
		end else begin
			adc_start <= start_ok; // RQ4
			if (wr & sel_ctrl) begin
				adc_chnum <= pwdata[`CTRL_CHAN_LSB +: 5]; // RQ7
				adc_mode <= pwdata[`CTRL_MODE_LSB +: 2]; // RQ7
			end
			conv_pending <= start_ok | (conv_pending & ~adc_datavalid);
			if (adc_datavalid) begin
				last_result <= adc_result;
			end
		end
	end

	// ==========================================================
	// config mux clock divider, 10 MHz or slower
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			div_count <= 8'h00;
			cfgmux_clk <= 1'b0;
		end else begin
			if (div_tick) begin
				div_count <= 8'h00;
				cfgmux_clk <= ~cfgmux_clk; // RQ2 RQ3
			end else begin
				div_count <= div_count + 8'h01;
			end
		end
	end

	// ==========================================================
	// config mux transfer: set up on a falling edge, sampled on the
	// rising one, released on the next falling edge
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cfg_state <= CFG_IDLE;
			cfg_pending <= 1'b0;
			cfg_write <= 1'b0;
			cfg_addr_q <= 8'h00;
			cfg_data_q <= 8'h00;
			cfg_read_data <= 8'h00;
			cfgmux_wen <= 1'b0;
			cfgmux_addr <= 8'h00;
			cfgmux_wdata <= 8'h00;
		end else begin
			if (cfg_ok) begin
				cfg_pending <= 1'b1;
				cfg_write <= pwdata[`CFG_WRITE_BIT];
				cfg_addr_q <= pwdata[15:8];
				cfg_data_q <= pwdata[7:0];
			end
			unique case (cfg_state)
				CFG_IDLE: begin
					if (fall_tick & cfg_pending) begin
						cfg_pending <= 1'b0;
						cfgmux_addr <= cfg_addr_q; // RQ3
						cfgmux_wdata <= cfg_data_q; // RQ3
						cfgmux_wen <= cfg_write; // RQ3
						cfg_state <= CFG_SETUP;
					end
				end
				CFG_SETUP: begin
					if (rise_tick) begin
						cfg_read_data <= cfgmux_rdata;
						cfg_state <= CFG_HOLD;
					end
				end
				CFG_HOLD: begin
					if (cfg_done) begin
						cfgmux_wen <= 1'b0;
						cfg_state <= CFG_IDLE;
					end
				end
			endcase
		end
	end

	// ==========================================================
	// interrupt: sticky status, a new event beats its clear
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			irq_status <= '0;
			irq_enable <= `IRQ_ENABLE_RESET;
			level_prev <= 4'h0;
			irq <= ~`IRQ_ACTIVE_HIGH;
		end else begin
			level_prev <= levels;
			irq_status <= (irq_status & ~irq_clear) | events; // RQ11 RQ13
			if (wr & sel_irq_enable) begin
				irq_enable <= pwdata[`IRQ_WIDTH-1:0];
			end
			irq <= irq_any ~^ `IRQ_ACTIVE_HIGH; // RQ11 RQ13
		end
	end

endmodule

`default_nettype wire

/* File: apb_analog_block_interface_asserts.sv */
/*
 * checker for the analog block interface top ports.
 * assumes it is bound onto apb_analog_block_interface.
 */
`timescale 1ns/100ps
`default_nettype none
`include "analog_block_interface_defs.svh"

module apb_analog_block_interface_asserts (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// apb side
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	// config mux and adc
	input wire logic cfgmux_clk,
	input wire logic cfgmux_wen,
	input wire logic [7:0] cfgmux_addr,
	input wire logic adc_rst_n,
	input wire logic adc_calibrate,
	input wire logic adc_start,
	input wire logic adc_calibrating
);
	// one domain, so clock and reset are given once
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	// ==========================================================
	// apb handshake
	a_pready_no_wait: assert property (
		psel && penable && !pready |=> pready) else $error("pready late");
	a_pready_one_cycle: assert property (
		pready |=> !pready) else $error("pready too long");
	a_slverr_with_ready: assert property (
		pslverr |-> pready) else $error("pslverr alone");

	// ==========================================================
	// config mux clock and controls
	a_cfgclk_free_run: assert property (
		!$past(rst) |-> $changed(cfgmux_clk)) else $error("cfg clk stuck");
	a_cfg_addr_on_fall: assert property (
		$changed(cfgmux_addr) |-> $fell(cfgmux_clk)) else $error("addr moved");
	a_cfg_wen_period: assert property (
		$rose(cfgmux_wen) |-> !cfgmux_clk ##1 cfgmux_wen ##1 !cfgmux_wen)
		else $error("wen period wrong");

	// ==========================================================
	// adc start and calibration
	a_start_one_pulse: assert property (
		adc_start |=> !adc_start) else $error("start too long");
	a_start_from_apb: assert property (
		adc_start |-> pready && $past(pwrite) && $past(paddr) == `OFS_CTRL)
		else $error("start without write");
	a_start_after_cal: assert property (
		adc_start |-> adc_rst_n && !adc_calibrating)
		else $error("start before ready");
	a_cal_after_reset: assert property (
		$rose(adc_rst_n) |=> adc_calibrate) else $error("no calibrate");
endmodule

bind apb_analog_block_interface apb_analog_block_interface_asserts chk (
	.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
	.cfgmux_clk(cfgmux_clk), .cfgmux_wen(cfgmux_wen),
	.cfgmux_addr(cfgmux_addr), .adc_rst_n(adc_rst_n),
	.adc_calibrate(adc_calibrate), .adc_start(adc_start),
	.adc_calibrating(adc_calibrating));
`default_nettype wire

/* File: apb_analog_block_interface_test.sv */
/*
 * self-checking bench: apb master, analog block model, result checks.
 * assumes the design's registers and timing as handed over.
 */
`timescale 1ns/100ps
`default_nettype none
`include "analog_block_interface_defs.svh"
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
	$display("Error %s expected %h seen %h", nm, e, g); end end

module apb_analog_block_interface_test;
	logic sys_clk, rst, psel, penable, pwrite, slow, pready, pslverr, irq;
	logic cfgmux_clk, cfgmux_wen, adc_rst_n, adc_calibrate, adc_start;
	logic adc_calibrating, adc_busy, adc_datavalid;
	logic [7:0] paddr, cfgmux_addr, cfgmux_wdata, cfgmux_rdata, a, d;
	logic [31:0] pwdata, prdata;
	logic [4:0] adc_chnum;
	logic [1:0] adc_mode;
	logic [11:0] adc_result;
	logic [6:0] nconv; // conversions counted by the bench
	logic [64:0] note; // mask, expected value, expected error
	logic [64:0] q[$];
	logic [11:0] res[$];
	int n_fail, tests_run, cyc, i, j, k;

	apb_analog_block_interface apb_analog_block_interface_inst (
		.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cfgmux_clk(cfgmux_clk),
		.cfgmux_wen(cfgmux_wen), .cfgmux_addr(cfgmux_addr),
		.cfgmux_wdata(cfgmux_wdata), .cfgmux_rdata(cfgmux_rdata),
		.adc_rst_n(adc_rst_n), .adc_calibrate(adc_calibrate),
		.adc_start(adc_start), .adc_chnum(adc_chnum), .adc_mode(adc_mode),
		.adc_calibrating(adc_calibrating), .adc_busy(adc_busy),
		.adc_datavalid(adc_datavalid), .adc_result(adc_result), .irq(irq));
	analog_block_model analog_block_model_inst (
		.sys_clk(sys_clk), .rst(rst), .slow(slow), .adc_rst_n(adc_rst_n),
		.adc_calibrate(adc_calibrate), .adc_start(adc_start),
		.adc_chnum(adc_chnum), .adc_calibrating(adc_calibrating),
		.adc_busy(adc_busy), .adc_datavalid(adc_datavalid),
		.adc_result(adc_result), .cfgmux_clk(cfgmux_clk),
		.cfgmux_wen(cfgmux_wen), .cfgmux_addr(cfgmux_addr),
		.cfgmux_wdata(cfgmux_wdata), .cfgmux_rdata(cfgmux_rdata));

	// ==========================================================
	// clock and hang guard
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			wrap_up();
		end
	end

	// ==========================================================
	// result watcher: oldest note against each finished transfer
	always @(posedge sys_clk) begin
		if (pready === 1'b1) begin
			note = q.pop_front();
			`CHK("prdata", note[32:1], prdata & note[64:33])
			`CHK("pslverr", note[0], pslverr)
		end
	end

	// ==========================================================
	// apb master: hold everything until pready is sampled high
	task apb(input logic w, input logic [7:0] ad, input logic [31:0] dt,
		input logic [31:0] m, input logic [31:0] e, input logic er);
		q.push_back({m, e, er});
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= dt;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		for (k = 0; k < 8 && pready !== 1'b1; k++) @(posedge sys_clk);
		expect_seen(pready);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [7:0] ad, input logic [31:0] dt);
		apb(1'b1, ad, dt, 32'h0, 32'h0, 1'b0);
	endtask
	task rd(input logic [7:0] ad, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, ad, 32'h0, m, e, 1'b0);
	endtask
	// one conversion at random speed, waits for its result word
	task conv(input logic [4:0] c);
		slow <= 1'($urandom);
		wr(`OFS_CTRL, {19'h0, c, 8'h01});
		for (j = 0; j < 40 && adc_datavalid !== 1'b1; j++) @(posedge sys_clk);
		expect_seen(adc_datavalid);
		res.push_back({c, nconv});
		nconv++;
		repeat (3) @(posedge sys_clk);
	endtask
	// a wait that ran out of cycles is a failure, so end the run there
	task expect_seen(input logic seen);
		if (seen !== 1'b1) begin
			n_fail++;
			wrap_up();
		end
	endtask
	task wrap_up();
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// ==========================================================
	// main sequence
	initial begin
		void'($urandom(16584));
		{rst, psel, penable, pwrite, slow, paddr, pwdata} = '0;
		rst = 1'b1;
		nconv = 7'h00;
		repeat (5) @(posedge sys_clk);
		rst <= 1'b0;
		wr(`OFS_CTRL, 32'h1);
		for (i = 0; i < 200 && adc_calibrating !== 1'b1; i++) @(posedge sys_clk);
		expect_seen(adc_calibrating);
		for (i = 0; i < 200 && adc_calibrating !== 1'b0; i++) @(posedge sys_clk);
		expect_seen(~adc_calibrating);
		repeat (3) @(posedge sys_clk);
		rd(`OFS_STATUS, 32'h1, 32'h1);
		rd(`OFS_IRQ_STATUS, 32'h202, 32'h202);
		apb(1'b0, 8'h20, 32'h0, 32'h0, 32'h0, 1'b1);
		// channel setup through the config mux before any conversion
		a = 8'($urandom);
		d = 8'($urandom);
		wr(`OFS_CFG, {15'h0, 1'b1, a, d});
		repeat (8) @(posedge sys_clk);
		wr(`OFS_CFG, {15'h0, 1'b0, a, 8'h00});
		repeat (8) @(posedge sys_clk);
		rd(`OFS_CFG, 32'h1ffff, {15'h0, 1'b0, a, d});
		// conversions pile up unread, then drain in order
		wr(`OFS_IRQ_ENABLE, 32'h1);
		wr(`OFS_IRQ_STATUS, 32'h3fff);
		for (i = 0; i < 4; i++) conv(5'($urandom));
		`CHK("irq", 1'b1, irq)
		rd(`OFS_STATUS, 32'h1ff7f, 32'h411);
		// valid flag sits in bit 15 and is checked with the 12-bit result; bits 14:12 are masked out of the compare
		for (i = 0; i < 4; i++) begin
			rd(`OFS_RESULT, 32'h8fff, {20'h00008, res.pop_front()});
		end
		rd(`OFS_RESULT, 32'h8000, 32'h0);
		wr(`OFS_IRQ_STATUS, 32'h3fff);
		repeat (3) @(posedge sys_clk);
		`CHK("irq", 1'b0, irq)
		for (i = 0; i < 4; i++) begin
			wr(`OFS_CTRL, 32'(i) << 13);
			`CHK("adc_mode", 2'(i), adc_mode)
		end
		// second start while converting is refused
		slow <= 1'b1;
		wr(`OFS_CTRL, 32'h1);
		wr(`OFS_CTRL, 32'h1);
		for (j = 0; j < 40 && adc_datavalid !== 1'b1; j++) @(posedge sys_clk);
		expect_seen(adc_datavalid);
		nconv++;
		rd(`OFS_IRQ_STATUS, 32'h200, 32'h200);
		// fill to the brim, then one more is lost
		for (i = 0; i < 255; i++) conv(5'($urandom));
		rd(`OFS_STATUS, 32'h1ff7f, 32'h10061);
		conv(5'h00);
		rd(`OFS_IRQ_STATUS, 32'h40, 32'h40);
		wrap_up();
	end
endmodule
`default_nettype wire

/* File: result_fifo.sv */
/*
 * Result FIFO for ADC conversion words.
 * Assumes push and pop are single-cycle strobes on sys_clk.
 */
`timescale 1ns/100ps
`default_nettype none

module result_fifo (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// write side
	input wire logic push,
	input wire logic [11:0] wr_data,
	// read side
	input wire logic pop,
	output logic [11:0] rd_data,
	// occupancy
	output logic [8:0] count,
	output logic empty,
	output logic full
);

	logic [11:0] mem [0:`FIFO_DEPTH-1]; // result storage
	logic [`FIFO_AW-1:0] wr_ptr; // next slot to fill
	logic [`FIFO_AW-1:0] rd_ptr; // oldest result
	wire do_push = push & ~full; // a full fifo drops the word
	wire do_pop = pop & ~empty;

	assign rd_data = mem[rd_ptr];
	assign empty = (count == 9'h000);
	assign full = (count == 9'(`FIFO_DEPTH));

	// ==========================================================
	// storage, no reset so it maps onto block ram
	always_ff @(posedge sys_clk) begin
		if (do_push) begin
			mem[wr_ptr] <= wr_data;
		end
	end

	// ==========================================================
	// pointers and count
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= 9'h000;
		end else begin
			if (do_push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (do_pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
			// push and pop together leave the count alone unless the fifo is empty or full
			count <= count + 9'(do_push) - 9'(do_pop);
		end
	end

endmodule

`default_nettype wire
